// File: core/dace_unit.sv
`include "dace_params.svh"
`default_nettype none
module dace_unit
    import dace_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Storage access, one per access even within one instruction
    input  wire logic        acc_valid,
    input  wire logic        acc_is_write,
    input  wire logic [31:0] acc_addr,
    input  wire logic [31:0] acc_pc,
    input  wire logic        data_space_bit,
    // Debug mode and interrupt enable
    input  wire logic        mode_external,
    input  wire logic        mode_wait,
    input  wire logic        mode_internal,
    input  wire logic        mode_trace,
    input  wire logic        debug_irq_enable,
    // Configuration
    input  wire logic [3:0]  event_enables,
    input  wire logic [1:0]  compare_mode_select,
    input  wire logic [1:0]  event1_space_qualifier,
    input  wire logic [1:0]  event2_space_qualifier,
    input  wire logic [3:0]  value1_byte_enables,
    input  wire logic [3:0]  value2_byte_enables,
    input  wire logic        async_select,
    input  wire logic [31:0] ref_addr1,
    input  wire logic [31:0] ref_addr2,
    // Status clear, one bit per status flag, bit 4 is imprecise flag
    input  wire logic [4:0]  status_clear,
    // Results
    output logic [3:0]       debug_status_reg,
    output logic             imprecise_event_flag,
    output logic             acc_stall,
    output logic             suppress,
    output logic             stop_req,
    output logic             debug_irq,
    output logic [31:0]      critical_save_pc,
    output logic             trace_event
);
    logic [1:0] hit;
    logic [3:0] ev;
    logic [3:0] st_r, st_nxt;
    logic       ide_r, ide_nxt;
    logic       stall_r, stall_nxt;
    logic       sup_r, sup_nxt;
    logic       stop_r, stop_nxt;
    logic       irq_r, irq_nxt;
    logic       trc_r, trc_nxt;
    logic [31:0] pc_r, pc_nxt;
    logic       any_ev;
    logic       sync_md;
    logic       ext_md;
    logic       armed;
    dace_act_t  act;

    //----------------------------------------
    // Address match per event
    //----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ev
            dace_match u_match (
                .addr      (acc_addr),
                .ds_bit    (data_space_bit),
                .mode      (compare_mode_select),
                .qual      (g == 0 ? event1_space_qualifier
                                   : event2_space_qualifier),
                .ref_a     (ref_addr1),
                .ref_b     (ref_addr2),
                .is_second (g == 1),
                .hit       (hit[g])
            );
        end
    endgenerate

    //----------------------------------------
    // Event qualification
    //----------------------------------------
    // Value compare is outside this block, so nonzero enables mute the event
    always_comb begin
        ev[`DACE_ST_E1R] = acc_valid && !acc_is_write && hit[0]
            && event_enables[`DACE_ST_E1R]
            && (value1_byte_enables == `DACE_BE_OFF);
        ev[`DACE_ST_E1W] = acc_valid && acc_is_write && hit[0]
            && event_enables[`DACE_ST_E1W]
            && (value1_byte_enables == `DACE_BE_OFF);
        ev[`DACE_ST_E2R] = acc_valid && !acc_is_write && hit[1]
            && event_enables[`DACE_ST_E2R]
            && (value2_byte_enables == `DACE_BE_OFF);
        ev[`DACE_ST_E2W] = acc_valid && acc_is_write && hit[1]
            && event_enables[`DACE_ST_E2W]
            && (value2_byte_enables == `DACE_BE_OFF);
    end

    assign any_ev  = |ev;
    assign ext_md  = mode_external || mode_wait;
    assign sync_md = !async_select;
    // Any non-trace mode with enabled events costs a cycle in sync mode
    assign armed   = (|event_enables) && !mode_trace
                     && (ext_md || mode_internal);

    //----------------------------------------
    // Action select
    //----------------------------------------
    // Trace wins over other modes; external beats internal
    always_comb begin
        act = DACE_IDLE;
        if (any_ev) begin
            if (mode_trace)
                act = DACE_TRACE;
            else if (ext_md)
                act = DACE_STOP;
            else if (mode_internal && debug_irq_enable)
                act = DACE_IRQ;
            else
                act = DACE_IDLE; // Imprecise path handled below
        end
    end

    //----------------------------------------
    // Next state
    //----------------------------------------
    // Set beats clear so no event is lost in a clearing cycle
    always_comb begin
        st_nxt    = (st_r & ~status_clear[3:0]) | ev;
        ide_nxt   = ide_r && !status_clear[4];
        stall_nxt = acc_valid && armed && sync_md && !stall_r;
        sup_nxt   = 1'b0;
        stop_nxt  = 1'b0;
        irq_nxt   = 1'b0;
        trc_nxt   = 1'b0;
        pc_nxt    = pc_r;
        case (act)
            DACE_TRACE: trc_nxt = 1'b1;
            DACE_STOP: begin
                stop_nxt = 1'b1;
                sup_nxt  = sync_md; // Async: may complete first
                pc_nxt   = acc_pc;
            end
            DACE_IRQ: begin
                irq_nxt = 1'b1;
                sup_nxt = sync_md;
                pc_nxt  = acc_pc;
            end
            DACE_IDLE: begin
                if (any_ev && !mode_trace && !ext_md && mode_internal)
                    ide_nxt = 1'b1;
            end
            default: ;
        endcase
        // Delayed interrupt once enabled while status still pending
        if (act == DACE_IDLE && ide_r && debug_irq_enable && mode_internal
            && !ext_md && !mode_trace && (|st_r)) begin
            irq_nxt = 1'b1;
            pc_nxt  = acc_pc;
        end
    end

    // Register stage
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r    <= 4'h0;
            ide_r   <= 1'b0;
            stall_r <= 1'b0;
            sup_r   <= 1'b0;
            stop_r  <= 1'b0;
            irq_r   <= 1'b0;
            trc_r   <= 1'b0;
            pc_r    <= 32'h0;
        end else begin
            st_r    <= st_nxt;
            ide_r   <= ide_nxt;
            stall_r <= stall_nxt;
            sup_r   <= sup_nxt;
            stop_r  <= stop_nxt;
            irq_r   <= irq_nxt;
            trc_r   <= trc_nxt;
            pc_r    <= pc_nxt;
        end
    end

    assign debug_status_reg     = st_r;
    assign imprecise_event_flag = ide_r;
    assign acc_stall            = stall_r;
    assign suppress             = sup_r;
    assign stop_req             = stop_r;
    assign debug_irq            = irq_r;
    assign critical_save_pc     = pc_r;
    assign trace_event          = trc_r;

    //----------------------------------------
    // Checks
    //----------------------------------------
    a_status_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ev[0] |=> debug_status_reg[0]) else $error("status not set");
    a_status_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        debug_status_reg[1] && !status_clear[1] |=> debug_status_reg[1])
        else $error("status dropped");
    a_byte_mute: assert property (@(posedge sys_clk) disable iff (sys_rst)
        value1_byte_enables != 4'h0 |-> !ev[0] && !ev[1])
        else $error("event with byte enables");
    a_reserved_qual: assert property (@(posedge sys_clk) disable iff (sys_rst)
        event2_space_qualifier == 2'b01 |-> !ev[2] && !ev[3])
        else $error("reserved qualifier fired");
    a_ds0_qual: assert property (@(posedge sys_clk) disable iff (sys_rst)
        event1_space_qualifier == 2'b10 && data_space_bit |-> !ev[0] && !ev[1])
        else $error("space 0 qualifier wrong");
    a_ds1_qual: assert property (@(posedge sys_clk) disable iff (sys_rst)
        event1_space_qualifier == 2'b11 && !data_space_bit
        |-> !ev[0] && !ev[1])
        else $error("space 1 qualifier wrong");
    a_stop_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
        any_ev && !mode_trace && ext_md && !async_select
        |=> stop_req && suppress && critical_save_pc == $past(acc_pc))
        else $error("sync stop wrong");
    a_irq_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
        any_ev && !mode_trace && !ext_md && mode_internal && debug_irq_enable
        |=> debug_irq && critical_save_pc == $past(acc_pc))
        else $error("sync irq wrong");
    a_trace_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
        any_ev && mode_trace |=> trace_event && !stop_req && !suppress)
        else $error("trace path wrong");
    a_imprecise: assert property (@(posedge sys_clk) disable iff (sys_rst)
        any_ev && !mode_trace && !ext_md && mode_internal && !debug_irq_enable
        |=> imprecise_event_flag && !suppress) else $error("ide not set");
    a_stall_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        acc_valid && armed && !async_select && !acc_stall |=> acc_stall)
        else $error("no extra cycle");
    a_async_nostall: assert property (@(posedge sys_clk) disable iff (sys_rst)
        async_select |=> !acc_stall) else $error("async stalled");

    c_stop: cover property (@(posedge sys_clk) stop_req);
    c_irq: cover property (@(posedge sys_clk) debug_irq && !suppress);
    c_trace: cover property (@(posedge sys_clk) trace_event);
    c_ide: cover property (@(posedge sys_clk) imprecise_event_flag ##1 debug_irq);
endmodule
`default_nettype wire

// File: core/dace_params.svh
`ifndef DACE_PARAMS_SVH
`define DACE_PARAMS_SVH
`define DACE_AW          32
`define DACE_QUAL_ANY    2'b00
`define DACE_QUAL_REAL   2'b01
`define DACE_QUAL_DS0    2'b10
`define DACE_QUAL_DS1    2'b11
`define DACE_MODE_EXACT  2'b00
`define DACE_MODE_MASK   2'b01
`define DACE_MODE_INCL   2'b10
`define DACE_MODE_EXCL   2'b11
`define DACE_BE_OFF      4'h0
`define DACE_ST_E1R      0
`define DACE_ST_E1W      1
`define DACE_ST_E2R      2
`define DACE_ST_E2W      3
`define DACE_EXTRA_CYC   1
`endif

// File: core/dace_pkg.sv
`default_nettype none
package dace_pkg;
    // Action taken on a qualified event
    typedef enum logic [4:0] {
        DACE_IDLE  = 5'h01,
        DACE_STALL = 5'h02,
        DACE_STOP  = 5'h04,
        DACE_IRQ   = 5'h08,
        DACE_TRACE = 5'h10
    } dace_act_t;
endpackage
`default_nettype wire

// File: core/dace_match.sv
`include "dace_params.svh"
`default_nettype none
module dace_match
    import dace_pkg::*;
(
    // Access
    input  wire logic [31:0] addr,
    input  wire logic        ds_bit,
    // Setup
    input  wire logic [1:0]  mode,
    input  wire logic [1:0]  qual,
    input  wire logic [31:0] ref_a,
    input  wire logic [31:0] ref_b,
    input  wire logic        is_second,
    // Result
    output logic             hit
);
    logic addr_ok;
    logic qual_ok;

    // Address compare; paired modes share both reference values
    always_comb begin
        case (mode)
            `DACE_MODE_EXACT: addr_ok = (addr == (is_second ? ref_b : ref_a));
            `DACE_MODE_MASK:  addr_ok = ((addr ^ ref_a) & ref_b) == 32'h0;
            `DACE_MODE_INCL:  addr_ok = (addr >= ref_a) && (addr < ref_b);
            default:          addr_ok = (addr < ref_a) || (addr >= ref_b);
        endcase
    end

    // Space qualifier; no process id input exists by design
    always_comb begin
        case (qual)
            `DACE_QUAL_ANY: qual_ok = 1'b1;
            `DACE_QUAL_DS0: qual_ok = (ds_bit == 1'b0);
            `DACE_QUAL_DS1: qual_ok = (ds_bit == 1'b1);
            default:        qual_ok = 1'b0;            // Reserved
        endcase
    end

    assign hit = addr_ok && qual_ok;
endmodule
`default_nettype wire

// File: testbench/dace_pipe_model.sv
`default_nettype none
module dace_pipe_model (
    // Clock
    input  wire logic       sys_clk,
    // Storage access toward the unit
    output var logic        acc_valid,
    output var logic        acc_is_write,
    output var logic [31:0] acc_addr,
    output var logic [31:0] acc_pc,
    output var logic        data_space_bit
);
    timeunit 1ns;
    timeprecision 100ps;

    // -------------
    // Pipeline side
    // -------------
    // Quiet until the first access
    initial begin
        acc_valid = 1'b0;
        acc_is_write = 1'b0;
        acc_addr = 32'h0;
        acc_pc = 32'h0;
        data_space_bit = 1'b0;
    end

    // One access per call, each judged alone
    // Idle bus shows the inverse so stale values never match
    task automatic issue(input logic w, input logic [31:0] a,
                         input logic [31:0] pc, input logic ds);
        @(posedge sys_clk);
        #1;
        acc_valid = 1'b1;
        acc_is_write = w;
        acc_addr = a;
        acc_pc = pc;
        data_space_bit = ds;
        @(posedge sys_clk);
        #1;
        acc_valid = 1'b0;
        acc_addr = ~a;
        acc_pc = ~pc;
    endtask

    // Two reads of one instruction on back-to-back cycles
    task automatic issue_pair(input logic [31:0] a, input logic [31:0] b,
                              input logic [31:0] pc);
        @(posedge sys_clk);
        #1;
        acc_valid = 1'b1;
        acc_is_write = 1'b0;
        acc_addr = a;
        acc_pc = pc;
        @(posedge sys_clk);
        #1;
        acc_addr = b;
        @(posedge sys_clk);
        #1;
        acc_valid = 1'b0;
        acc_addr = ~b;
        acc_pc = ~pc;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // -------
    // Signals
    // -------
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        acc_valid, acc_is_write, data_space_bit;
    logic [31:0] acc_addr, acc_pc, ref_addr1, ref_addr2;
    logic        mode_external, mode_wait, mode_internal, mode_trace;
    logic        debug_irq_enable, async_select;
    logic [3:0]  event_enables, value1_byte_enables, value2_byte_enables;
    logic [1:0]  compare_mode_select;
    logic [1:0]  event1_space_qualifier, event2_space_qualifier;
    logic [4:0]  status_clear;
    logic [3:0]  debug_status_reg;
    logic        imprecise_event_flag, acc_stall, suppress, stop_req;
    logic        debug_irq, trace_event;
    logic [31:0] critical_save_pc;
    int          fail_count = 0;
    int          tests_run = 0;

    // 200 MHz core clock
    always #2.5 sys_clk = ~sys_clk;

    dace_unit dut_u (
        .sys_clk, .sys_rst, .acc_valid, .acc_is_write, .acc_addr,
        .acc_pc, .data_space_bit, .mode_external, .mode_wait,
        .mode_internal, .mode_trace, .debug_irq_enable, .event_enables,
        .compare_mode_select, .event1_space_qualifier,
        .event2_space_qualifier, .value1_byte_enables,
        .value2_byte_enables, .async_select, .ref_addr1, .ref_addr2,
        .status_clear, .debug_status_reg, .imprecise_event_flag,
        .acc_stall, .suppress, .stop_req, .debug_irq, .critical_save_pc,
        .trace_event
    );

    dace_pipe_model pipe_u (
        .sys_clk, .acc_valid, .acc_is_write, .acc_addr, .acc_pc,
        .data_space_bit
    );

    // -------
    // Helpers
    // -------
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Order: external, wait, internal, trace
    task automatic set_mode(logic [3:0] m);
        {mode_external, mode_wait, mode_internal, mode_trace} = m;
    endtask

    // Sticky flags drop only on an explicit clear pulse or a reset
    task automatic clr();
        @(posedge sys_clk);
        #1 status_clear = 5'h1f;
        @(posedge sys_clk);
        #1 status_clear = 5'h00;
    endtask

    // ---------
    // Scenarios
    // ---------
    // Space qualifier against data space bit, in trace mode
    task automatic t_qual();
        logic [1:0] q;
        logic       e;
        set_mode(4'b0001);
        for (int i = 0; i < 8; i++) begin
            q = i[2:1];
            event1_space_qualifier = q;
            e = (q == 2'b00) || (q == {1'b1, i[0]});
            pipe_u.issue(1'b0, 32'h100, 32'h40, i[0]);
            chk("status", debug_status_reg, {3'h0, e});
            chk("trace", trace_event, e);
            chk("stall", acc_stall, 0);
            clr();
        end
        event1_space_qualifier = 2'b00;
    endtask

    // Stop and interrupt actions over external, wait and internal modes, sync then async
    task automatic t_act();
        logic [3:0] dm [3] = '{4'b1000, 4'b0100, 4'b0010};
        debug_irq_enable = 1'b1;
        event_enables = 4'h3;
        for (int i = 0; i < 6; i++) begin
            set_mode(dm[i/2]);
            async_select = i[0];
            pipe_u.issue(1'b1, 32'h100, 32'h2000 + i, 1'b0);
            chk("status", debug_status_reg, 4'h2);
            chk("stop", stop_req, i < 4);
            chk("irq", debug_irq, i >= 4);
            chk("suppress", suppress, !i[0]);
            chk("stall", acc_stall, !i[0]);
            chk("save pc", critical_save_pc, 32'h2000 + i);
            clr();
        end
        set_mode(4'b1000);
        async_select = 1'b0;
        pipe_u.issue(1'b0, 32'h104, 32'h50, 1'b0);
        chk("stall miss", acc_stall, 1);
        chk("stop miss", stop_req, 0);
        value1_byte_enables = 4'h3;
        pipe_u.issue(1'b1, 32'h100, 32'h54, 1'b0);
        chk("muted", debug_status_reg, 0);
        value1_byte_enables = 4'h0;
        debug_irq_enable = 1'b0;
    endtask

    // Held flag in internal mode raises the delayed interrupt
    task automatic t_impr();
        set_mode(4'b0010);
        event_enables = 4'h1;
        pipe_u.issue(1'b0, 32'h100, 32'h3000, 1'b0);
        chk("imprecise", imprecise_event_flag, 1);
        chk("suppress", suppress, 0);
        chk("irq", debug_irq, 0);
        repeat (4) @(posedge sys_clk);
        #1 chk("held", debug_status_reg, 4'h1);
        debug_irq_enable = 1'b1;
        @(posedge sys_clk);
        #1 chk("late irq", debug_irq, 1);
        clr();
        debug_irq_enable = 1'b0;
    endtask

    // Compare modes on event one: {mode, address, expected}
    task automatic t_range();
        logic [34:0] tab [8] = '{
            {2'b00, 32'h100, 1'b1}, {2'b00, 32'h200, 1'b0},
            {2'b01, 32'h001, 1'b1}, {2'b01, 32'h300, 1'b0},
            {2'b10, 32'h100, 1'b1}, {2'b10, 32'h200, 1'b0},
            {2'b11, 32'h0ff, 1'b1}, {2'b11, 32'h100, 1'b0}};
        set_mode(4'b0001);
        event2_space_qualifier = 2'b00;
        for (int i = 0; i < 8; i++) begin
            compare_mode_select = tab[i][34:33];
            pipe_u.issue(1'b0, tab[i][32:1], 32'h60, 1'b0);
            chk("mode", debug_status_reg, {3'h0, tab[i][0]});
            clr();
        end
    endtask

    // Event two: reserved and space 1 qualifiers, byte enable mute
    task automatic t_ev2();
        set_mode(4'b0001);
        compare_mode_select = 2'b00;
        event_enables = 4'hc;
        event2_space_qualifier = 2'b01;
        pipe_u.issue(1'b1, 32'h200, 32'h90, 1'b0);
        chk("ev2 reserved", debug_status_reg, 0);
        event2_space_qualifier = 2'b11;
        pipe_u.issue(1'b0, 32'h200, 32'h94, 1'b1);
        chk("ev2 space 1", debug_status_reg, 4'h4);
        clr();
        value2_byte_enables = 4'h8;
        pipe_u.issue(1'b0, 32'h200, 32'h98, 1'b1);
        chk("ev2 muted", debug_status_reg, 0);
        value2_byte_enables = 4'h0;
        event2_space_qualifier = 2'b00;
    endtask

    // Two accesses of one instruction, only the second one matching
    task automatic t_multi();
        set_mode(4'b1000);
        async_select = 1'b0;
        event_enables = 4'h1;
        pipe_u.issue_pair(32'h104, 32'h100, 32'h70);
        chk("pair status", debug_status_reg, 4'h1);
        chk("pair stop", stop_req, 1);
        chk("pair pc", critical_save_pc, 32'h70);
        chk("pair stall", acc_stall, 0);
        clr();
    endtask

    // Reset in mid-run drops the sticky flags
    task automatic t_rst();
        set_mode(4'b0010);
        event_enables = 4'h1;
        pipe_u.issue(1'b0, 32'h100, 32'h80, 1'b0);
        chk("pre reset ide", imprecise_event_flag, 1);
        sys_rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        chk("reset status", debug_status_reg, 0);
        chk("reset ide", imprecise_event_flag, 0);
    endtask

    // Main sequence after a six cycle reset
    initial begin
        status_clear = 5'h00;
        set_mode(4'b0001);
        debug_irq_enable = 1'b0;
        event_enables = 4'h1;
        compare_mode_select = 2'b00;
        event1_space_qualifier = 2'b00;
        event2_space_qualifier = 2'b00;
        value1_byte_enables = 4'h0;
        value2_byte_enables = 4'h0;
        async_select = 1'b0;
        ref_addr1 = 32'h100;
        ref_addr2 = 32'h200;
        repeat (6) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        t_qual();
        t_act();
        t_impr();
        t_ev2();
        t_multi();
        t_rst();
        t_range();
        tally_and_finish();
    end

    // The run needs about 124 cycles; this is far beyond
    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
